// File: src/pdoss_pkg.sv
// Constants, register map and state codes of the PLL divider and output source select block.
// Assumes one 100 MHz host clock; all users qualify names with the package scope.
package pdoss_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  // Length of one oscillator calibration pass
  localparam int CAL_TIME_NS = 20000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Host registers
  // ************************************************************
  localparam logic [7:0] REF_SELECT_ADDR = 8'h30;
  localparam logic [7:0] REF_PATH_ADDR = 8'h4e;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int SELECT_MSB = 4;
  localparam int PATH_ENABLE_BIT = 5;
  localparam logic [4:0] SELECT_REF_ZERO = 5'h01;
  localparam logic [4:0] SELECT_REF_ONE = 5'h02;

  // ************************************************************
  // Source codes and divider limits
  // ************************************************************
  localparam logic [1:0] SRC_RESONATOR = 2'h0;
  localparam logic [1:0] SRC_LC_TANK = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL = 2'h2;
  localparam logic [1:0] SRC_REFERENCE = 2'h3;
  localparam logic [32:0] DIV_BYPASS = 33'h1;
  localparam logic [3:0] RES_DIV_MAX = 4'h8;
  localparam logic [3:0] LC_DIV_MIN = 4'h2;
  localparam logic [3:0] LC_DIV_MAX = 4'hd;
  localparam int BANK_B_FIRST = 4;
  localparam int BANK_C_FIRST = 8;
  localparam int OUT_COUNT = 12;

  // ************************************************************
  // Synchroniser lanes
  // ************************************************************
  localparam int IDX_RES_VCO = 0;
  localparam int IDX_LC_VCO = 1;
  localparam int IDX_CRYSTAL = 2;
  localparam int IDX_REF_ZERO = 3;
  localparam int IDX_REF_ONE = 4;
  localparam int IDX_RES_LOCK = 5;
  localparam int SYNC_W = 7;

  typedef enum logic [4:0] {
    CAL_OFF = 5'b00001,
    CAL_WAIT_XO = 5'b00010,
    CAL_RUN = 5'b00100,
    CAL_WAIT_LOCK = 5'b01000,
    CAL_READY = 5'b10000
  } pdoss_cal_state_type;

endpackage

// File: src/pdoss_top.sv
// Calibration sequencing, PLL dividers, digital loop and output source muxes.
// Assumes host controls come from REF_CLK logic; clocks and lock pins are asynchronous.
//
// Behaviour
// - Auto calibrate each PLL once crystal present
// - Mute selected outputs until PLL ready
// - Enable bit 0 to 1 recalibrates that PLL
// - Resonator post divider 2-8, optional half
// - Resonator post divider 1 bypasses
// - LC tank post divider 2 to 13
// - Sixteen-bit divider per reference input
// - Digitizer emits reference to feedback phase error
// - Loop filter steers analog numerator
// - Loop bandwidth programmable 10 mHz-4 kHz
// - 33-bit feedback prescaler
// - Feedback divides integer plus numerator/denominator
// - Sync event aligns output divider phases
// - Zero delay sync on outputs 0, 10
// - Private four-input selectors, three shared two-input
// - Selector choices per selector kind
// - Reference option needs select code, path enable
// - Fixed denominator with digital PLL active
module pdoss_top #(
  parameter int CAL_COUNT = pdoss_pkg::CAL_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic HOST_WRITE,
  input wire logic HOST_READ,
  input wire logic [7:0] HOST_ADDR,
  input wire logic [7:0] HOST_WRITE_DATA,
  output logic [7:0] HOST_READ_DATA,
  input wire logic RESONATOR_PLL_CLK,
  input wire logic LC_TANK_PLL_CLK,
  input wire logic CRYSTAL_REFERENCE_INPUT,
  input wire logic REFERENCE_INPUT_ZERO,
  input wire logic REFERENCE_INPUT_ONE,
  input wire logic RESONATOR_PLL_LOCK,
  input wire logic LC_TANK_PLL_LOCK,
  input wire logic CRYSTAL_PRESENT,
  input wire logic [1:0] ANALOG_PLL_ENABLE_BIT,
  output logic [1:0] CALIBRATING,
  output logic [1:0] PLL_READY,
  input wire logic [11:0] OUTPUT_MUTE_OPTION,
  output logic [11:0] OUTPUT_MUTE,
  input wire logic [3:0] RESONATOR_POST_DIVIDE,
  input wire logic RESONATOR_EXTRA_HALF,
  input wire logic [3:0] LC_TANK_POST_DIVIDE,
  input wire logic [15:0] REFERENCE_DIVIDE_ZERO,
  input wire logic [15:0] REFERENCE_DIVIDE_ONE,
  input wire logic DIGITIZER_REFERENCE_SELECT,
  input wire logic [32:0] FEEDBACK_PRESCALE,
  input wire logic [32:0] FEEDBACK_INTEGER,
  input wire logic [39:0] FEEDBACK_NUMERATOR,
  input wire logic [39:0] FEEDBACK_DENOMINATOR,
  output logic [15:0] PHASE_CORRECTION,
  output logic PHASE_CORRECTION_VALID,
  input wire logic DIGITAL_PLL_ACTIVE,
  input wire logic [3:0] LOOP_BANDWIDTH_CODE,
  input wire logic [39:0] NUMERATOR_BASE,
  input wire logic [23:0] PROGRAMMED_DENOMINATOR,
  output logic [39:0] ANALOG_NUMERATOR,
  output logic [23:0] ANALOG_DENOMINATOR,
  output logic ANALOG_DENOMINATOR_FIXED,
  input wire logic OUTPUT_SYNC_REQUEST,
  output logic DIVIDER_SYNC,
  input wire logic [1:0] ZERO_DELAY_ENABLE,
  input wire logic [15:0] ZERO_DELAY_OFFSET_OUT0,
  input wire logic [15:0] ZERO_DELAY_OFFSET_OUT10,
  output logic [1:0] ZERO_DELAY_SYNC,
  input wire logic [1:0] OUT0_SOURCE,
  input wire logic [1:0] OUT1_SOURCE,
  input wire logic [2:0] BANK_SOURCE,
  output logic [4:0] SOURCE_CLOCK
);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [32:0] div_step(input logic [32:0] cnt, input logic [32:0] lim);
    return ({1'b0, cnt} + 34'h1 >= {1'b0, lim}) ? 33'h0 : cnt + 33'h1;
  endfunction

  // Limit of one or zero passes the raw clock through
  function automatic logic div_level(input logic [32:0] cnt, input logic [32:0] lim,
                                     input logic raw);
    return (lim <= pdoss_pkg::DIV_BYPASS) ? raw : (cnt < (lim >> 1));
  endfunction

  function automatic logic src_ready(input logic [1:0] src, input logic [1:0] rdy);
    if (src == pdoss_pkg::SRC_RESONATOR) return rdy[0];
    if (src == pdoss_pkg::SRC_LC_TANK) return rdy[1];
    return 1'b1;
  endfunction

  function automatic int bank_of(input int k);
    return (k < pdoss_pkg::BANK_B_FIRST) ? 0 : ((k < pdoss_pkg::BANK_C_FIRST) ? 1 : 2);
  endfunction

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [pdoss_pkg::SYNC_W-1:0] sync_a;
  logic [pdoss_pkg::SYNC_W-1:0] sync_b;
  logic [pdoss_pkg::SYNC_W-1:0] sync_c;
  logic [pdoss_pkg::SYNC_W-1:0] rise;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= {LC_TANK_PLL_LOCK, RESONATOR_PLL_LOCK, REFERENCE_INPUT_ONE,
                 REFERENCE_INPUT_ZERO, CRYSTAL_REFERENCE_INPUT, LC_TANK_PLL_CLK,
                 RESONATOR_PLL_CLK};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign rise = sync_b & ~sync_c;

  // ************************************************************
  // Host registers
  // ************************************************************
  logic [7:0] output_reference_select;
  logic [7:0] output_reference_path_enable;

  // New select codes act from the cycle after the write
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      output_reference_select <= pdoss_pkg::REG_RESET;
      output_reference_path_enable <= pdoss_pkg::REG_RESET;
    end else if (HOST_WRITE) begin
      if (HOST_ADDR == pdoss_pkg::REF_SELECT_ADDR) output_reference_select <= HOST_WRITE_DATA;
      if (HOST_ADDR == pdoss_pkg::REF_PATH_ADDR) output_reference_path_enable <= HOST_WRITE_DATA;
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) HOST_READ_DATA <= '0;
    else if (HOST_READ && HOST_ADDR == pdoss_pkg::REF_SELECT_ADDR) begin
      HOST_READ_DATA <= output_reference_select;
    end else if (HOST_READ && HOST_ADDR == pdoss_pkg::REF_PATH_ADDR) begin
      HOST_READ_DATA <= output_reference_path_enable;
    end else HOST_READ_DATA <= '0;
  end

  // ************************************************************
  // Calibration sequencing
  // ************************************************************
  logic [1:0] ready;

  for (genvar i = 0; i < 2; i++) begin : g_cal
    pdoss_pkg::pdoss_cal_state_type state;
    logic en_q;
    logic [12:0] cal_cnt;
    logic lock;

    assign lock = sync_b[pdoss_pkg::IDX_RES_LOCK + i];

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) en_q <= '0;
      else en_q <= ANALOG_PLL_ENABLE_BIT[i];
    end

    // Start-up pass waits for the crystal; only a 0 to 1 toggle restarts
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        state <= pdoss_pkg::CAL_WAIT_XO;
        cal_cnt <= '0;
      end else if (!ANALOG_PLL_ENABLE_BIT[i]) begin
        state <= pdoss_pkg::CAL_OFF;
      end else if (!en_q) begin
        state <= pdoss_pkg::CAL_WAIT_XO;
      end else begin
        unique case (state)
          pdoss_pkg::CAL_OFF: state <= pdoss_pkg::CAL_OFF;
          pdoss_pkg::CAL_WAIT_XO: begin
            if (CRYSTAL_PRESENT) begin
              state <= pdoss_pkg::CAL_RUN;
              cal_cnt <= 13'(CAL_COUNT - 1);
            end
          end
          pdoss_pkg::CAL_RUN: begin
            if (cal_cnt == '0) state <= pdoss_pkg::CAL_WAIT_LOCK;
            else cal_cnt <= cal_cnt - 13'h1;
          end
          pdoss_pkg::CAL_WAIT_LOCK: begin
            if (lock) state <= pdoss_pkg::CAL_READY;
          end
          pdoss_pkg::CAL_READY: state <= pdoss_pkg::CAL_READY;
          default: state <= pdoss_pkg::CAL_OFF;
        endcase
      end
    end

    assign CALIBRATING[i] = (state == pdoss_pkg::CAL_RUN);
    assign ready[i] = (state == pdoss_pkg::CAL_READY);

    a_cal_start: assert property ((state == pdoss_pkg::CAL_WAIT_XO) && en_q
      && ANALOG_PLL_ENABLE_BIT[i] && CRYSTAL_PRESENT |=> CALIBRATING[i] [*2])
      else $error("calibration did not start on crystal");
    a_enable_recal: assert property ($rose(ANALOG_PLL_ENABLE_BIT[i])
      |=> state == pdoss_pkg::CAL_WAIT_XO)
      else $error("enable toggle did not restart calibration");
    a_no_recal: assert property (ready[i] && $stable(ANALOG_PLL_ENABLE_BIT[i])
      && ANALOG_PLL_ENABLE_BIT[i] |=> ready[i])
      else $error("calibration restarted without enable toggle");
  end

  assign PLL_READY = ready;

  // ************************************************************
  // Post dividers and sync
  // ************************************************************
  logic sync_q;
  logic sync_rise;
  logic [3:0] res_lim;
  logic [3:0] lc_lim;
  logic [32:0] res_cnt;
  logic [32:0] lc_cnt;
  logic res_div;
  logic res_div_q;
  logic res_half;
  logic res_post;
  logic lc_post;

  assign sync_rise = OUTPUT_SYNC_REQUEST & ~sync_q;
  assign res_lim = (RESONATOR_POST_DIVIDE > pdoss_pkg::RES_DIV_MAX) ?
                   pdoss_pkg::RES_DIV_MAX : RESONATOR_POST_DIVIDE;
  assign lc_lim = (LC_TANK_POST_DIVIDE < pdoss_pkg::LC_DIV_MIN) ? pdoss_pkg::LC_DIV_MIN :
                  ((LC_TANK_POST_DIVIDE > pdoss_pkg::LC_DIV_MAX) ?
                   pdoss_pkg::LC_DIV_MAX : LC_TANK_POST_DIVIDE);

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_q <= '0;
      DIVIDER_SYNC <= '0;
    end else begin
      sync_q <= OUTPUT_SYNC_REQUEST;
      DIVIDER_SYNC <= sync_rise;
    end
  end

  // Sync clears every post-divider phase so all banks restart together
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      res_cnt <= '0;
      res_div <= '0;
      res_div_q <= '0;
      res_half <= '0;
    end else begin
      if (sync_rise) res_cnt <= '0;
      else if (rise[pdoss_pkg::IDX_RES_VCO]) res_cnt <= div_step(res_cnt, 33'(res_lim));
      res_div <= div_level(res_cnt, 33'(res_lim), sync_b[pdoss_pkg::IDX_RES_VCO]);
      res_div_q <= res_div;
      if (sync_rise) res_half <= '0;
      else if (res_div && !res_div_q) res_half <= ~res_half;
    end
  end

  assign res_post = RESONATOR_EXTRA_HALF ? res_half : res_div;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lc_cnt <= '0;
      lc_post <= '0;
    end else begin
      if (sync_rise) lc_cnt <= '0;
      else if (rise[pdoss_pkg::IDX_LC_VCO]) lc_cnt <= div_step(lc_cnt, 33'(lc_lim));
      lc_post <= div_level(lc_cnt, 33'(lc_lim), sync_b[pdoss_pkg::IDX_LC_VCO]);
    end
  end

  // ************************************************************
  // Reference dividers
  // ************************************************************
  logic [32:0] ref_cnt [2];
  logic [1:0] ref_div;
  logic [1:0] ref_div_q;
  logic [15:0] ref_lim [2];
  logic sel_rise;

  assign ref_lim[0] = REFERENCE_DIVIDE_ZERO;
  assign ref_lim[1] = REFERENCE_DIVIDE_ONE;

  for (genvar r = 0; r < 2; r++) begin : g_ref
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        ref_cnt[r] <= '0;
        ref_div[r] <= '0;
        ref_div_q[r] <= '0;
      end else begin
        if (rise[pdoss_pkg::IDX_REF_ZERO + r]) ref_cnt[r] <= div_step(ref_cnt[r], 33'(ref_lim[r]));
        ref_div[r] <= div_level(ref_cnt[r], 33'(ref_lim[r]), sync_b[pdoss_pkg::IDX_REF_ZERO + r]);
        ref_div_q[r] <= ref_div[r];
      end
    end
  end

  assign sel_rise = ref_div[DIGITIZER_REFERENCE_SELECT] & ~ref_div_q[DIGITIZER_REFERENCE_SELECT];

  // ************************************************************
  // Feedback path
  // ************************************************************
  logic [32:0] pre_cnt;
  logic [32:0] fb_cnt;
  logic [32:0] next_fb_cnt;
  logic [39:0] frac_acc;
  logic [40:0] frac_sum;
  logic carry;
  logic pre_wrap;
  logic fb_edge;

  assign pre_wrap = rise[pdoss_pkg::IDX_RES_VCO] && (div_step(pre_cnt, FEEDBACK_PRESCALE) == '0);
  assign next_fb_cnt = div_step(fb_cnt, FEEDBACK_INTEGER + 33'(carry));
  assign frac_sum = {1'b0, frac_acc} + {1'b0, FEEDBACK_NUMERATOR};

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pre_cnt <= '0;
      fb_cnt <= '0;
      frac_acc <= '0;
      carry <= '0;
      fb_edge <= '0;
    end else begin
      if (rise[pdoss_pkg::IDX_RES_VCO]) pre_cnt <= div_step(pre_cnt, FEEDBACK_PRESCALE);
      fb_edge <= pre_wrap && (next_fb_cnt == '0);
      if (pre_wrap) begin
        fb_cnt <= next_fb_cnt;
        if (next_fb_cnt == '0) begin
          // Carry adds one count to the next period
          if (frac_sum >= {1'b0, FEEDBACK_DENOMINATOR}) begin
            frac_acc <= 40'(frac_sum - {1'b0, FEEDBACK_DENOMINATOR});
            carry <= 1'b1;
          end else begin
            frac_acc <= frac_sum[39:0];
            carry <= 1'b0;
          end
        end
      end
    end
  end

  // ************************************************************
  // Phase digitizer and loop filter
  // ************************************************************
  logic [15:0] stamp;
  logic [15:0] ref_stamp;
  logic [39:0] integ;
  logic [39:0] gain;

  // Word wraps; phase errors beyond half the stamp range alias
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stamp <= '0;
      ref_stamp <= '0;
      PHASE_CORRECTION <= '0;
      PHASE_CORRECTION_VALID <= '0;
    end else begin
      stamp <= stamp + 16'h1;
      if (sel_rise) ref_stamp <= stamp;
      if (fb_edge) PHASE_CORRECTION <= stamp - ref_stamp;
      PHASE_CORRECTION_VALID <= fb_edge;
    end
  end

  // Larger code gives more gain, so a wider bandwidth
  assign gain = {{24{PHASE_CORRECTION[15]}}, PHASE_CORRECTION} << LOOP_BANDWIDTH_CODE;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      integ <= '0;
      ANALOG_NUMERATOR <= '0;
    end else if (!DIGITAL_PLL_ACTIVE) begin
      integ <= '0;
      ANALOG_NUMERATOR <= NUMERATOR_BASE;
    end else if (PHASE_CORRECTION_VALID) begin
      integ <= integ + gain;
      ANALOG_NUMERATOR <= NUMERATOR_BASE + integ + gain;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ANALOG_DENOMINATOR_FIXED <= '0;
      ANALOG_DENOMINATOR <= '0;
    end else begin
      ANALOG_DENOMINATOR_FIXED <= DIGITAL_PLL_ACTIVE;
      ANALOG_DENOMINATOR <= DIGITAL_PLL_ACTIVE ? '0 : PROGRAMMED_DENOMINATOR;
    end
  end

  // ************************************************************
  // Zero delay alignment
  // ************************************************************
  logic [15:0] zoff [2];
  logic [15:0] zcnt [2];
  logic [1:0] zarm;

  assign zoff[0] = ZERO_DELAY_OFFSET_OUT0;
  assign zoff[1] = ZERO_DELAY_OFFSET_OUT10;

  for (genvar z = 0; z < 2; z++) begin : g_zdly
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        zcnt[z] <= '0;
        zarm[z] <= '0;
        ZERO_DELAY_SYNC[z] <= '0;
      end else begin
        ZERO_DELAY_SYNC[z] <= zarm[z] && (zcnt[z] == '0);
        if (ZERO_DELAY_ENABLE[z] && sel_rise) begin
          zcnt[z] <= zoff[z];
          zarm[z] <= 1'b1;
        end else if (zarm[z]) begin
          if (zcnt[z] == '0) zarm[z] <= 1'b0;
          else zcnt[z] <= zcnt[z] - 16'h1;
        end
      end
    end
  end

  // ************************************************************
  // Output source muxes and mute
  // ************************************************************
  logic ref_opt;

  always_comb begin
    ref_opt = 1'b0;
    if (output_reference_path_enable[pdoss_pkg::PATH_ENABLE_BIT]) begin
      if (output_reference_select[pdoss_pkg::SELECT_MSB:0] == pdoss_pkg::SELECT_REF_ZERO) begin
        ref_opt = sync_b[pdoss_pkg::IDX_REF_ZERO];
      end else if (output_reference_select[pdoss_pkg::SELECT_MSB:0] == pdoss_pkg::SELECT_REF_ONE) begin
        ref_opt = sync_b[pdoss_pkg::IDX_REF_ONE];
      end
    end
  end

  function automatic logic pick(input logic [1:0] src, input logic res, input logic lc,
                                input logic xo, input logic rf);
    unique case (src)
      pdoss_pkg::SRC_RESONATOR: return res;
      pdoss_pkg::SRC_LC_TANK: return lc;
      pdoss_pkg::SRC_CRYSTAL: return xo;
      pdoss_pkg::SRC_REFERENCE: return rf;
    endcase
  endfunction

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) SOURCE_CLOCK <= '0;
    else begin
      SOURCE_CLOCK[0] <= pick(OUT0_SOURCE, res_post, lc_post,
                              sync_b[pdoss_pkg::IDX_CRYSTAL], ref_opt);
      SOURCE_CLOCK[1] <= pick(OUT1_SOURCE, res_post, lc_post,
                              sync_b[pdoss_pkg::IDX_CRYSTAL], ref_opt);
      for (int b = 0; b < 3; b++) SOURCE_CLOCK[2 + b] <= BANK_SOURCE[b] ? lc_post : res_post;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) OUTPUT_MUTE <= '0;
    else begin
      OUTPUT_MUTE[0] <= OUTPUT_MUTE_OPTION[0] & ~src_ready(OUT0_SOURCE, ready);
      OUTPUT_MUTE[1] <= OUTPUT_MUTE_OPTION[1] & ~src_ready(OUT1_SOURCE, ready);
      for (int k = 2; k < pdoss_pkg::OUT_COUNT; k++) begin
        OUTPUT_MUTE[k] <= OUTPUT_MUTE_OPTION[k] & ~src_ready({1'b0, BANK_SOURCE[bank_of(k)]}, ready);
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************

  a_mute_until_ready: assert property (OUTPUT_MUTE_OPTION[0] && !ready[0]
    && OUT0_SOURCE == pdoss_pkg::SRC_RESONATOR |=> OUTPUT_MUTE[0])
    else $error("output not muted before lock");
  a_bypass_follow: assert property (RESONATOR_POST_DIVIDE == 4'h1 && !RESONATOR_EXTRA_HALF
    |=> res_post == $past(sync_b[pdoss_pkg::IDX_RES_VCO]))
    else $error("post divider bypass not transparent");
  a_lc_range: assert property (lc_cnt < 33'(pdoss_pkg::LC_DIV_MAX))
    else $error("lc tank divider count out of range");
  a_ref_gate: assert property (!output_reference_path_enable[pdoss_pkg::PATH_ENABLE_BIT]
    && OUT0_SOURCE == pdoss_pkg::SRC_REFERENCE |=> !SOURCE_CLOCK[0])
    else $error("reference reached output with path disabled");
  a_bank_source: assert property (!BANK_SOURCE[0] |=> SOURCE_CLOCK[2] == $past(res_post))
    else $error("shared selector picked wrong source");
  a_base_numerator: assert property (!DIGITAL_PLL_ACTIVE
    |=> ANALOG_NUMERATOR == $past(NUMERATOR_BASE) && integ == '0)
    else $error("numerator not at base with loop off");
  a_fixed_den: assert property (DIGITAL_PLL_ACTIVE |=> ANALOG_DENOMINATOR_FIXED
    && ANALOG_DENOMINATOR == '0)
    else $error("denominator not fixed with loop active");
  a_sync_pulse: assert property ($rose(OUTPUT_SYNC_REQUEST) |=> DIVIDER_SYNC
    && res_cnt == '0 ##1 !DIVIDER_SYNC)
    else $error("sync pulse malformed");
  a_phase_valid: assert property (fb_edge |=> PHASE_CORRECTION_VALID ##1 !PHASE_CORRECTION_VALID
    || fb_edge)
    else $error("correction word not flagged");

  c_pll_ready: cover property ($rose(ready[0]));
  c_zero_delay: cover property ($rose(ZERO_DELAY_SYNC[0]));
  c_correction: cover property (PHASE_CORRECTION_VALID && DIGITAL_PLL_ACTIVE);
  c_ref_output: cover property (ref_opt && OUT1_SOURCE == pdoss_pkg::SRC_REFERENCE);

endmodule // pdoss_top

// File: tb/tb_pdoss_top.sv
// Self-checking bench of the divider and source select block.
// Assumes src/pdoss_pkg.sv and src/pdoss_top.sv are compiled first.
module tb_pdoss_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Stimulus
  // ************************************************************
  logic REF_CLK = 0, RESET_N = 0, HOST_WRITE = 0, HOST_READ = 0, CRYSTAL_PRESENT = 0;
  logic [7:0] HOST_ADDR = 8'h00, HOST_WRITE_DATA = 8'h00, HOST_READ_DATA, d, q;
  logic RESONATOR_PLL_CLK = 0, LC_TANK_PLL_CLK = 0, CRYSTAL_REFERENCE_INPUT = 0;
  logic REFERENCE_INPUT_ZERO = 0, REFERENCE_INPUT_ONE = 0, RESONATOR_PLL_LOCK = 0;
  logic LC_TANK_PLL_LOCK = 0, RESONATOR_EXTRA_HALF = 0, DIGITIZER_REFERENCE_SELECT = 0;
  logic DIGITAL_PLL_ACTIVE = 0, OUTPUT_SYNC_REQUEST = 0;
  logic [1:0] ANALOG_PLL_ENABLE_BIT = 2'h3, ZERO_DELAY_ENABLE = 2'h0;
  logic [1:0] OUT0_SOURCE = 2'h0, OUT1_SOURCE = 2'h0, CALIBRATING, PLL_READY, ZERO_DELAY_SYNC;
  logic [11:0] OUTPUT_MUTE_OPTION = 12'hfff, OUTPUT_MUTE;
  logic [3:0] RESONATOR_POST_DIVIDE = 4'h1, LC_TANK_POST_DIVIDE = 4'h2, LOOP_BANDWIDTH_CODE;
  logic [15:0] REFERENCE_DIVIDE_ZERO = 16'h1, REFERENCE_DIVIDE_ONE = 16'h1, PHASE_CORRECTION;
  logic [15:0] ZERO_DELAY_OFFSET_OUT0 = 16'h3, ZERO_DELAY_OFFSET_OUT10 = 16'h3;
  logic [32:0] FEEDBACK_PRESCALE = 33'h1, FEEDBACK_INTEGER = 33'h4;
  logic [39:0] FEEDBACK_NUMERATOR = 40'h0, FEEDBACK_DENOMINATOR = 40'h1, NUMERATOR_BASE;
  logic [39:0] ANALOG_NUMERATOR;
  logic [23:0] PROGRAMMED_DENOMINATOR, ANALOG_DENOMINATOR;
  logic [2:0] BANK_SOURCE = 3'h0;
  logic [4:0] SOURCE_CLOCK;
  logic PHASE_CORRECTION_VALID, ANALOG_DENOMINATOR_FIXED, DIVIDER_SYNC, path;
  int err_total = 0, comparisons = 0, seed = 32'h0c01;
  // Short calibration pass keeps the run brief
  pdoss_top #(.CAL_COUNT(4)) u_pdoss_top (.REF_CLK, .RESET_N, .HOST_WRITE, .HOST_READ,
    .HOST_ADDR, .HOST_WRITE_DATA, .HOST_READ_DATA, .RESONATOR_PLL_CLK, .LC_TANK_PLL_CLK,
    .CRYSTAL_REFERENCE_INPUT, .REFERENCE_INPUT_ZERO, .REFERENCE_INPUT_ONE,
    .RESONATOR_PLL_LOCK, .LC_TANK_PLL_LOCK, .CRYSTAL_PRESENT, .ANALOG_PLL_ENABLE_BIT,
    .CALIBRATING, .PLL_READY, .OUTPUT_MUTE_OPTION, .OUTPUT_MUTE, .RESONATOR_POST_DIVIDE,
    .RESONATOR_EXTRA_HALF, .LC_TANK_POST_DIVIDE, .REFERENCE_DIVIDE_ZERO, .REFERENCE_DIVIDE_ONE,
    .DIGITIZER_REFERENCE_SELECT, .FEEDBACK_PRESCALE, .FEEDBACK_INTEGER, .FEEDBACK_NUMERATOR,
    .FEEDBACK_DENOMINATOR, .PHASE_CORRECTION, .PHASE_CORRECTION_VALID, .DIGITAL_PLL_ACTIVE,
    .LOOP_BANDWIDTH_CODE, .NUMERATOR_BASE, .PROGRAMMED_DENOMINATOR, .ANALOG_NUMERATOR,
    .ANALOG_DENOMINATOR, .ANALOG_DENOMINATOR_FIXED, .OUTPUT_SYNC_REQUEST, .DIVIDER_SYNC,
    .ZERO_DELAY_ENABLE, .ZERO_DELAY_OFFSET_OUT0, .ZERO_DELAY_OFFSET_OUT10, .ZERO_DELAY_SYNC,
    .OUT0_SOURCE, .OUT1_SOURCE, .BANK_SOURCE, .SOURCE_CLOCK);
  always #5 REF_CLK = ~REF_CLK;
  // ************************************************************
  // Tasks and expectations
  // ************************************************************
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    HOST_ADDR = a; HOST_WRITE_DATA = v; HOST_WRITE = 1; cyc(1); HOST_WRITE = 0; cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    HOST_ADDR = a; HOST_READ = 1; cyc(1); v = HOST_READ_DATA; HOST_READ = 0; cyc(1);
  endtask
  // Reference option is low unless path enabled and code valid
  function automatic logic exp_src(input logic [1:0] s, input logic [4:0] c, input logic p);
    case (s)
      2'h0: return RESONATOR_PLL_CLK;
      2'h2: return CRYSTAL_REFERENCE_INPUT;
      default: return p && (c == 5'h01) ? REFERENCE_INPUT_ZERO :
                      p && (c == 5'h02) ? REFERENCE_INPUT_ONE : 1'b0;
    endcase
  endfunction
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    end_of_test;
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    LOOP_BANDWIDTH_CODE = 4'($random(seed));
    NUMERATOR_BASE = {8'h00, 32'($random(seed))};
    PROGRAMMED_DENOMINATOR = 24'($random(seed));
    repeat (5) @(posedge REF_CLK);
    #1 RESET_N = 1;
    rd(8'h30, q); chk(q, 8'h00);
    cyc(3); chk(CALIBRATING, 2'h0);
    CRYSTAL_PRESENT = 1;
    repeat (4) if (CALIBRATING !== 2'h3) cyc(1);
    chk(CALIBRATING, 2'h3);
    chk(OUTPUT_MUTE, 12'hfff);
    RESONATOR_PLL_LOCK = 1; LC_TANK_PLL_LOCK = 1;
    repeat (20) if (PLL_READY !== 2'h3) cyc(1);
    chk(PLL_READY, 2'h3); cyc(2); chk(OUTPUT_MUTE, 12'h000);
    ANALOG_PLL_ENABLE_BIT[0] = 0; cyc(2); ANALOG_PLL_ENABLE_BIT[0] = 1;
    repeat (6) if (CALIBRATING[0] !== 1'b1) cyc(1);
    chk(CALIBRATING, 2'h1); chk(PLL_READY[1], 1'b1);
    cyc(1); chk(OUTPUT_MUTE[0], 1'b1);
    repeat (20) if (PLL_READY !== 2'h3) cyc(1);
    chk(PLL_READY, 2'h3);
    // Random register traffic and static source levels through the muxes
    for (int i = 0; i < 16; i++) begin
      d = 8'($random(seed)); d[4:0] = {3'h0, (i < 8) ? i[1:0] : d[1:0]};
      path = d[pdoss_pkg::PATH_ENABLE_BIT];
      wr(8'h4e, d); wr(8'h30, d ^ 8'he0); wr(8'h31, d);
      rd(8'h4e, q); chk(q, d);
      rd(8'h31, q); chk(q, 8'h00);
      rd(8'h30, q); chk(q, d ^ 8'he0);
      {RESONATOR_PLL_CLK, CRYSTAL_REFERENCE_INPUT, REFERENCE_INPUT_ZERO} = 3'($random(seed));
      REFERENCE_INPUT_ONE = ~REFERENCE_INPUT_ZERO;
      {OUT0_SOURCE, OUT1_SOURCE} = 4'($random(seed)) | 4'ha;
      if (i < 4) {OUT0_SOURCE, OUT1_SOURCE} = 4'hf;
      cyc(6);
      chk(SOURCE_CLOCK[0], exp_src(OUT0_SOURCE, d[4:0], path));
      chk(SOURCE_CLOCK[1], exp_src(OUT1_SOURCE, d[4:0], path));
      chk(SOURCE_CLOCK[4:2], {3{RESONATOR_PLL_CLK}});
    end
    OUTPUT_SYNC_REQUEST = 1;
    repeat (3) if (DIVIDER_SYNC !== 1'b1) cyc(1);
    chk(DIVIDER_SYNC, 1'b1); cyc(1); chk(DIVIDER_SYNC, 1'b0);
    REFERENCE_INPUT_ZERO = 0; ZERO_DELAY_ENABLE = 2'h3; cyc(4);
    REFERENCE_INPUT_ZERO = 1;
    repeat (12) if (ZERO_DELAY_SYNC !== 2'h3) cyc(1);
    chk(ZERO_DELAY_SYNC, 2'h3); cyc(1); chk(ZERO_DELAY_SYNC, 2'h0);
    DIGITAL_PLL_ACTIVE = 1; cyc(3);
    chk({ANALOG_DENOMINATOR_FIXED, ANALOG_DENOMINATOR}, {1'b1, 24'h0});
    DIGITAL_PLL_ACTIVE = 0; cyc(3);
    chk({ANALOG_DENOMINATOR_FIXED, ANALOG_DENOMINATOR}, {1'b0, PROGRAMMED_DENOMINATOR});
    chk(ANALOG_NUMERATOR, NUMERATOR_BASE);
    end_of_test;
  end
endmodule // tb_pdoss_top
